// ---- core/spi_slave_defines.vh ----
// Constants for the serial peripheral slave engine
// How it works
// - Master-select clear makes clock, select inputs
// - Deselected output floats; selected drives bit, in single-wire mode only with bidirDriveEn set
// - Deselected slave ignores clock, never shifts
// - Phase clear: sample odd, shift even
// - Phase set: sample even, shift odd; eighth bit shifts on last even
// - First bit on select or first edge
// - After eight shifts set flag; copy byte only if flag was clear
// - Most significant bit goes first
// - Phase clear: half-period lead, sixteen edges
// - Phase set: first edge, then sampling edge
// - Polarity picks level, phase picks scheme
// - Select held low resends last received byte unless phase set and a byte is queued
// - Flag set right after the last edge
// - Received byte double buffered in data register
// - Single-wire mode uses output pin both ways
// - Flag clears: status read then data read
// - Enable dedicates pins; clear means inactive
`ifndef SPI_SLAVE_DEFINES_VH
`define SPI_SLAVE_DEFINES_VH

// Byte width and last bit index of a transfer
`define BYTE_W       8
`define LAST_BIT     3'h7
`define MSB_POS      7
`define NEXT_POS     6

// Reset values
`define DATA_RST     8'h00
`define CNT_RST      3'h0

`endif

// ---- core/spi_slave_transfer_formats.v ----
// Serial peripheral slave engine with both clock-phase transfer formats
`timescale 1ns/1ps
`include "spi_slave_defines.vh"

module spi_slave_transfer_formats (
    input  wire                 clk,
    input  wire                 nrst,
    input  wire                 moduleEnable,
    input  wire                 masterSelect,
    input  wire                 singleWireSelect,
    input  wire                 bidirDriveEn,
    input  wire                 clockPhaseSel,
    input  wire                 clockPolaritySel,
    input  wire [`BYTE_W-1:0]   txData,
    input  wire                 txWrite,
    input  wire                 statusRead,
    input  wire                 dataRead,
    input  wire                 sckPin,
    input  wire                 selectPinN,
    input  wire                 mosiPin,
    input  wire                 misoPinIn,
    output wire                 misoOut,
    output wire                 misoOe,
    output wire [`BYTE_W-1:0]   dataReg,
    output wire                 transferDoneFlag,
    output wire                 busy
);

    // =========================================================
    // Declarations
    // =========================================================
    // One-hot engine states
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_SEL  = 2'b10;

    reg  [1:0]          state_r;        // Engine state
    reg  [1:0]          state_nxt;
    reg                 sckMeta_r;      // Clock synchroniser stage 1
    reg                 sckSync_r;      // Clock synchroniser stage 2
    reg                 sckPrev_r;      // Clock for edge detect
    reg                 selMeta_r;      // Select stage 1
    reg                 selSync_r;      // Select stage 2
    reg                 mosiMeta_r;     // Data-in stage 1
    reg                 mosiSync_r;     // Data-in stage 2
    reg                 sioMeta_r;      // Shared pin stage 1
    reg                 sioSync_r;      // Shared pin stage 2
    reg  [`BYTE_W-1:0]  shifter_r;      // Serial shift register
    reg  [`BYTE_W-1:0]  shifter_nxt;
    reg  [`BYTE_W-1:0]  txBuf_r;        // Queued transmit byte
    reg                 txPend_r;       // Queued byte not yet loaded
    reg                 txPend_nxt;
    reg  [`BYTE_W-1:0]  dataReg_r;      // Parallel receive register
    reg  [`BYTE_W-1:0]  dataReg_nxt;
    reg                 doneFlag_r;     // Transfer complete flag
    reg                 doneFlag_nxt;
    reg                 statusSeen_r;   // Status read with flag set
    reg                 statusSeen_nxt;
    reg  [2:0]          bitCnt_r;       // Shifts done this byte
    reg  [2:0]          bitCnt_nxt;
    reg                 sampled_r;      // Latched serial input bit
    reg                 sampled_nxt;
    reg                 havePend_r;     // Latched bit awaits shift
    reg                 havePend_nxt;
    reg                 outBit_r;       // Bit driven on data out
    reg                 outBit_nxt;
    reg                 complete;       // Byte finished this cycle

    wire                selActive;      // Enabled slave, selected
    wire                leadEdge;       // Odd edge of the clock
    wire                trailEdge;      // Even edge of the clock
    wire                serialIn;       // Chosen serial input

    // Load value: new byte if queued, else last received byte
    function [`BYTE_W-1:0] loadByte;
        input                pend;
        input [`BYTE_W-1:0]  buf_;
        input [`BYTE_W-1:0]  cur;
        begin
            loadByte = pend ? buf_ : cur;
        end
    endfunction

    // Shift left, new bit into the least significant position
    function [`BYTE_W-1:0] shiftIn;
        input [`BYTE_W-1:0]  cur;
        input                bitIn;
        begin
            shiftIn = {cur[`BYTE_W-2:0], bitIn};
        end
    endfunction

    // =========================================================
    // Input synchronisers
    // =========================================================
    // two-flop synchronise pins
    always @(posedge clk) begin
        if (!nrst) begin
            // Select parks high so reset reads as deselected
            sckMeta_r  <= 1'b0;
            sckSync_r  <= 1'b0;
            sckPrev_r  <= 1'b0;
            selMeta_r  <= 1'b1;
            selSync_r  <= 1'b1;
            mosiMeta_r <= 1'b0;
            mosiSync_r <= 1'b0;
            sioMeta_r  <= 1'b0;
            sioSync_r  <= 1'b0;
        end else begin
            // Each pin moves one stage per clock
            sckMeta_r  <= sckPin;
            sckSync_r  <= sckMeta_r;
            sckPrev_r  <= sckSync_r;
            selMeta_r  <= selectPinN;
            selSync_r  <= selMeta_r;
            mosiMeta_r <= mosiPin;
            mosiSync_r <= mosiMeta_r;
            sioMeta_r  <= misoPinIn;
            sioSync_r  <= sioMeta_r;
        end
    end

    // =========================================================
    // Select qualification and edge detection
    // =========================================================
    // slave role only when enabled
    assign selActive = moduleEnable & ~masterSelect & ~selSync_r;

    // polarity only sets idle level
    // Lead edge leaves the idle level, trail returns
    assign leadEdge  = (sckSync_r != clockPolaritySel) &
                       (sckPrev_r == clockPolaritySel);
    assign trailEdge = (sckSync_r == clockPolaritySel) &
                       (sckPrev_r != clockPolaritySel);

    // single-wire input taken from shared pin
    assign serialIn  = singleWireSelect ? sioSync_r : mosiSync_r;

    // =========================================================
    // Engine next-state logic
    // =========================================================
    // Sampling, shifting, loading and completion
    always @* begin
        state_nxt      = state_r;
        shifter_nxt    = shifter_r;
        txPend_nxt     = txPend_r;
        dataReg_nxt    = dataReg_r;
        doneFlag_nxt   = doneFlag_r;
        statusSeen_nxt = statusSeen_r;
        bitCnt_nxt     = bitCnt_r;
        sampled_nxt    = sampled_r;
        havePend_nxt   = havePend_r;
        outBit_nxt     = outBit_r;
        complete       = 1'b0;

        case (state_r)
            ST_IDLE: begin
                bitCnt_nxt   = `CNT_RST;
                havePend_nxt = 1'b0;
                if (selActive) begin
                    // Select seen: byte starts
                    state_nxt = ST_SEL;
                    if (!clockPhaseSel) begin
                        shifter_nxt = loadByte(txPend_r, txBuf_r, shifter_r);
                        outBit_nxt  = shifter_nxt[`MSB_POS];
                        txPend_nxt  = 1'b0;
                    end
                end
            end
            ST_SEL: begin
                if (!selActive) begin
                    // Abandon any partial byte on deselect
                    state_nxt = ST_IDLE;
                end else if (!clockPhaseSel) begin
                    if (leadEdge) begin
                        // Odd edge latches the input bit
                        sampled_nxt = serialIn;
                    end else if (trailEdge) begin
                        // Even edge shifts, shows next bit
                        shifter_nxt = shiftIn(shifter_r, sampled_r);
                        outBit_nxt  = shifter_r[`NEXT_POS];
                        bitCnt_nxt  = bitCnt_r + 3'h1;
                        if (bitCnt_r == `LAST_BIT) begin
                            complete   = 1'b1;
                            bitCnt_nxt = `CNT_RST;
                        end
                    end
                end else begin
                    if (leadEdge) begin
                        if (!havePend_r) begin
                            shifter_nxt = loadByte(txPend_r, txBuf_r, shifter_r);
                            outBit_nxt  = shifter_nxt[`MSB_POS];
                            txPend_nxt  = 1'b0;
                        end else begin
                            // Later odd edges shift the latched bit
                            shifter_nxt  = shiftIn(shifter_r, sampled_r);
                            outBit_nxt   = shifter_r[`NEXT_POS];
                            havePend_nxt = 1'b0;
                            bitCnt_nxt   = bitCnt_r + 3'h1;
                        end
                    end else if (trailEdge) begin
                        if (bitCnt_r == `LAST_BIT) begin
                            // Eighth bit shifts in at once
                            shifter_nxt  = shiftIn(shifter_r, serialIn);
                            complete     = 1'b1;
                            bitCnt_nxt   = `CNT_RST;
                            havePend_nxt = 1'b0;
                        end else begin
                            // Even edge latches the input bit
                            sampled_nxt  = serialIn;
                            havePend_nxt = 1'b1;
                        end
                    end
                end
            end
            default: begin
                // Stray code falls back to idle
                state_nxt = ST_IDLE;
            end
        endcase

        // clear after status then data read
        if (statusRead && doneFlag_r) begin
            statusSeen_nxt = 1'b1;
        end
        // A data read alone never clears the flag
        if (dataRead && statusSeen_r) begin
            doneFlag_nxt   = 1'b0;
            statusSeen_nxt = 1'b0;
        end

        if (complete) begin
            // Unserviced flag keeps the old byte
            if (!doneFlag_r) begin
                dataReg_nxt = shifter_nxt;
            end
            doneFlag_nxt = 1'b1;
        end

        // Software write queues a byte and wins over a load
        if (txWrite) begin
            txPend_nxt = 1'b1;
        end
    end

    // =========================================================
    // Engine registers
    // =========================================================
    // State, shifter and flag storage
    always @(posedge clk) begin
        if (!nrst) begin
            // Idle, empty and flag clear
            state_r      <= ST_IDLE;
            shifter_r    <= `DATA_RST;
            txBuf_r      <= `DATA_RST;
            txPend_r     <= 1'b0;
            dataReg_r    <= `DATA_RST;
            doneFlag_r   <= 1'b0;
            statusSeen_r <= 1'b0;
            bitCnt_r     <= `CNT_RST;
            sampled_r    <= 1'b0;
            havePend_r   <= 1'b0;
            outBit_r     <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            shifter_r    <= shifter_nxt;
            txPend_r     <= txPend_nxt;
            dataReg_r    <= dataReg_nxt;
            doneFlag_r   <= doneFlag_nxt;
            statusSeen_r <= statusSeen_nxt;
            bitCnt_r     <= bitCnt_nxt;
            sampled_r    <= sampled_nxt;
            havePend_r   <= havePend_nxt;
            outBit_r     <= outBit_nxt;
            // Capture written byte
            if (txWrite) begin
                txBuf_r <= txData;
            end
        end
    end

    // =========================================================
    // Outputs
    // =========================================================
    // drive only while selected
    assign misoOe  = (state_r == ST_SEL) & selActive &
                     (~singleWireSelect | bidirDriveEn);
    // Out bit held in a flop between shift edges
    assign misoOut = outBit_r;

    // Data and flag straight from flops
    assign dataReg          = dataReg_r;
    assign transferDoneFlag = doneFlag_r;
    assign busy             = (state_r == ST_SEL);

endmodule

// ---- sim/spi_master_model.sv ----
// Behavioural master driving clock, select and serial data
`timescale 1ns/1ps
module spi_master_model #(parameter HALF = 80) (
    output reg  sck,
    output reg  selN,
    output reg  mosi,
    input  wire miso
);
    // ==========
    // One byte frame; ghost keeps select high
    initial begin
        sck = 1'b0;
        // model drives select; it starts high so the slave begins deselected
        selN = 1'b1;
        mosi = 1'b0;
    end
    // Idle clock level for the chosen polarity
    task park(input po);
        begin
            sck = po;
        end
    endtask
    task xfer(input ph, input po, input [7:0] tx, input keep, input ghost, output [7:0] rx);
        integer e;
        begin
            #3;
            sck = po;
            selN = ghost;
            mosi = tx[7];
            #HALF;
            for (e = 1; e <= 16; e = e + 1) begin
                if ((e % 2 == 1) != ph) rx = {rx[6:0], miso};
                sck = ~sck;
                if ((e % 2 == 1) == ph && e < 16) mosi = tx[7 - (e - ph) / 2];
                #HALF;
            end
            if (!keep) selN = 1'b1;
            mosi = ~mosi;
            #HALF;
        end
    endtask
endmodule

// ---- sim/spi_slave_asserts.sv ----
// Port checker for the serial slave engine
`timescale 1ns/1ps
module spi_slave_asserts (
    input wire       clk,
    input wire       nrst,
    input wire       moduleEnable,
    input wire       masterSelect,
    input wire       singleWireSelect,
    input wire       bidirDriveEn,
    input wire       statusRead,
    input wire       dataRead,
    input wire       selectPinN,
    input wire       misoOe,
    input wire [7:0] dataReg,
    input wire       transferDoneFlag,
    input wire       busy
);
    // ==========
    // Checks on the module clock
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_deselOe; selectPinN [*4] |-> !misoOe; endproperty
    a_deselOe: assert property (p_deselOe) else $error("output driven while deselected");
    property p_selOe; (moduleEnable && !masterSelect && !singleWireSelect && !selectPinN) [*5]
        |-> misoOe; endproperty
    a_selOe: assert property (p_selOe) else $error("output not driven while selected");
    property p_noShift; selectPinN [*6] |-> !$rose(transferDoneFlag); endproperty
    a_noShift: assert property (p_noShift) else $error("completion while deselected");
    property p_idle; selectPinN [*4] |-> !busy; endproperty
    a_idle: assert property (p_idle) else $error("busy while deselected");
    property p_master; masterSelect [*4] |-> !busy; endproperty
    a_master: assert property (p_master) else $error("busy in master role");
    property p_off; !moduleEnable [*4] |-> !misoOe; endproperty
    a_off: assert property (p_off) else $error("output driven while disabled");
    property p_hold; transferDoneFlag && !dataRead |=> transferDoneFlag; endproperty
    a_hold: assert property (p_hold) else $error("flag dropped without data read");
    property p_clear; (selectPinN [*4] ##0 (statusRead && transferDoneFlag)) ##1
        (dataRead && selectPinN) |=> !transferDoneFlag; endproperty
    a_clear: assert property (p_clear) else $error("flag kept after read pair");
    property p_copy; !$stable(dataReg) |-> $rose(transferDoneFlag); endproperty
    a_copy: assert property (p_copy) else $error("data changed without completion");
    property p_swHold; singleWireSelect && !bidirDriveEn |-> !misoOe; endproperty
    a_swHold: assert property (p_swHold) else $error("shared pin driven while held");
endmodule
bind spi_slave_transfer_formats spi_slave_asserts chk (
    .clk(clk), .nrst(nrst), .moduleEnable(moduleEnable), .masterSelect(masterSelect),
    .singleWireSelect(singleWireSelect), .bidirDriveEn(bidirDriveEn),
    .statusRead(statusRead), .dataRead(dataRead),
    .selectPinN(selectPinN), .misoOe(misoOe), .dataReg(dataReg),
    .transferDoneFlag(transferDoneFlag), .busy(busy)
);

// ---- sim/spi_slave_transfer_formats_tb.sv ----
// Self-checking bench for the serial slave engine
`timescale 1ns/1ps
module spi_slave_transfer_formats_tb;
    // ==========
    // Stimulus, wiring and tests
    reg        clk = 0, nrst = 0, moduleEnable = 0, masterSelect = 0, junk = 0;
    reg        clockPhaseSel = 0, clockPolaritySel = 0, txWrite = 0, statusRead = 0, dataRead = 0;
    reg        singleWire = 0, bidirDrive = 0;
    reg  [7:0] txData = 8'h00, rx;
    wire       sckPin, selectPinN, mosiPin, misoOut, misoOe, transferDoneFlag, busy, misoLine;
    wire       mosiToDut;
    wire [7:0] dataReg;
    integer    n_mismatch = 0, n_compared = 0, cycles = 0, i;
    // Released line toggles; single-wire puts master data on the shared pin
    assign misoLine  = misoOe ? misoOut : (singleWire ? mosiPin : junk);
    assign mosiToDut = singleWire ? junk : mosiPin;
    always #10 clk = ~clk;
    always @(posedge clk) begin
        junk <= ~junk;
        cycles = cycles + 1;
        if (cycles == 6000) begin
            n_mismatch = n_mismatch + 1;
            test_done;
        end
    end
    spi_slave_transfer_formats dut (.clk(clk), .nrst(nrst), .moduleEnable(moduleEnable),
        .masterSelect(masterSelect), .singleWireSelect(singleWire), .bidirDriveEn(bidirDrive),
        .clockPhaseSel(clockPhaseSel), .clockPolaritySel(clockPolaritySel), .txData(txData),
        .txWrite(txWrite), .statusRead(statusRead), .dataRead(dataRead), .sckPin(sckPin),
        .selectPinN(selectPinN), .mosiPin(mosiToDut), .misoPinIn(misoLine), .misoOut(misoOut),
        .misoOe(misoOe), .dataReg(dataReg), .transferDoneFlag(transferDoneFlag), .busy(busy));
    spi_master_model m (.sck(sckPin), .selN(selectPinN), .mosi(mosiPin), .miso(misoLine));
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task test_done;
        begin
            $display("compared %0d mismatches %0d", n_compared, n_mismatch);
            if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    task cfg(input ph, input po);
        begin
            @(posedge clk) moduleEnable <= 1'b0;
            repeat (5) @(posedge clk);
            clockPhaseSel <= ph;
            clockPolaritySel <= po;
            m.park(po);
            repeat (5) @(posedge clk);
            moduleEnable <= 1'b1;
            repeat (5) @(posedge clk);
        end
    endtask
    task load(input [7:0] tx);
        begin
            @(posedge clk) txData <= tx;
            txWrite <= 1'b1;
            @(posedge clk) txWrite <= 1'b0;
        end
    endtask
    task waitFlag;
        integer k;
        begin
            for (k = 0; k < 20 && transferDoneFlag !== 1'b1; k = k + 1) @(posedge clk);
            #1;
        end
    endtask
    task readClear;
        begin
            @(posedge clk) statusRead <= 1'b1;
            @(posedge clk) statusRead <= 1'b0;
            dataRead <= 1'b1;
            @(posedge clk) dataRead <= 1'b0;
            @(posedge clk) #1;
            chk("flag cleared", {7'h00, transferDoneFlag}, 8'h00);
        end
    endtask
    task t_format(input ph, input po, input [7:0] tx, input [7:0] mo);
        begin
            cfg(ph, po);
            load(tx);
            m.xfer(ph, po, mo, 1'b0, 1'b0, rx);
            chk("byte to master", rx, tx);
            waitFlag;
            chk("flag set", {7'h00, transferDoneFlag}, 8'h01);
            chk("received byte", dataReg, mo);
            readClear;
            $display("test format %0d%0d done", ph, po);
        end
    endtask
    task t_resend;
        begin
            cfg(1'b0, 1'b0);
            load(8'h5A);
            m.xfer(1'b0, 1'b0, 8'h96, 1'b1, 1'b0, rx);
            chk("first sent", rx, 8'h5A);
            waitFlag;
            chk("first received", dataReg, 8'h96);
            readClear;
            load(8'h11);
            m.xfer(1'b0, 1'b0, 8'h0F, 1'b0, 1'b0, rx);
            chk("resent byte", rx, 8'h96);
            waitFlag;
            chk("second byte", dataReg, 8'h0F);
            readClear;
            $display("test resend done");
        end
    endtask
    task t_overrun;
        begin
            cfg(1'b1, 1'b1);
            m.xfer(1'b1, 1'b1, 8'h77, 1'b0, 1'b0, rx);
            chk("queued byte", rx, 8'h11);
            waitFlag;
            @(posedge clk) dataRead <= 1'b1;
            @(posedge clk) dataRead <= 1'b0;
            m.xfer(1'b1, 1'b1, 8'h88, 1'b0, 1'b0, rx);
            chk("flag kept", {7'h00, transferDoneFlag}, 8'h01);
            chk("first byte kept", dataReg, 8'h77);
            readClear;
            m.xfer(1'b1, 1'b1, 8'h44, 1'b0, 1'b1, rx);
            repeat (10) @(posedge clk) #1;
            chk("ghost flag", {7'h00, transferDoneFlag}, 8'h00);
            chk("ghost drive", {7'h00, misoOe}, 8'h00);
            @(posedge clk) masterSelect <= 1'b1;
            m.xfer(1'b1, 1'b1, 8'h33, 1'b0, 1'b0, rx);
            repeat (10) @(posedge clk) #1;
            chk("master role flag", {7'h00, transferDoneFlag}, 8'h00);
            chk("master role data", dataReg, 8'h77);
            @(posedge clk) masterSelect <= 1'b0;
            $display("test overrun done");
        end
    endtask
    task t_reset;
        begin
            repeat (10) @(posedge clk);
            nrst <= 1'b1;
            @(posedge clk) #1;
            chk("reset data", dataReg, 8'h00);
            chk("reset flags", {5'h00, misoOe, transferDoneFlag, busy}, 8'h00);
            $display("test reset done");
        end
    endtask
    task t_wire;
        begin
            @(posedge clk) singleWire <= 1'b1;
            cfg(1'b0, 1'b0);
            load(8'h3C);
            m.xfer(1'b0, 1'b0, 8'h69, 1'b0, 1'b0, rx);
            waitFlag;
            chk("shared pin in", dataReg, 8'h69);
            readClear;
            @(posedge clk) bidirDrive <= 1'b1;
            load(8'hD2);
            m.xfer(1'b0, 1'b0, 8'h17, 1'b0, 1'b0, rx);
            chk("shared pin out", rx, 8'hD2);
            waitFlag;
            chk("own byte back", dataReg, 8'hD2);
            readClear;
            @(posedge clk) singleWire <= 1'b0;
            bidirDrive <= 1'b0;
            $display("test single wire done");
        end
    endtask
    initial begin
        t_reset;
        for (i = 0; i < 4; i = i + 1) t_format(i[1], i[0], 8'hA5 ^ i, 8'hC3 + i);
        t_resend;
        t_overrun;
        t_wire;
        test_done;
    end
endmodule
